// file: swd_pkg.sv
/*
 * Shared constants, types and register map of the slow clock watchdog.
 * Assumes a single 40 MHz bus clock; the slow clock exists only as an enable.
 */
package swd_pkg;

    // ----------------------------------------------------------------
    // Clock rates and derived cycle counts
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ      = 40_000_000;
    localparam int unsigned SLOW_HZ     = 32_768;
    // Bus cycles per slow clock period, rounded down.
    localparam int unsigned SLOW_DIV    = CLK_HZ / SLOW_HZ;

    // ----------------------------------------------------------------
    // Register indices; byte address is four times the index
    // ----------------------------------------------------------------
    localparam logic [15:0] IDX_REFRESH  = 16'h4026;
    localparam logic [15:0] IDX_RELOAD   = 16'h4027;
    localparam logic [15:0] IDX_CORE_CFG = 16'h401e;
    localparam logic [15:0] IDX_IRQ_STAT = 16'h4028;
    localparam logic [15:0] IDX_IRQ_EN   = 16'h4029;
    localparam logic [15:0] IDX_IRQ_CLR  = 16'h402a;
    localparam logic [15:0] IDX_RST_STAT = 16'h402b;

    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int unsigned REFRESH_POS  = 0;
    localparam int unsigned ENABLE_POS   = 5;
    localparam int unsigned RST_FLAG_POS = 0;
    localparam logic [7:0]  RELOAD_RST   = 8'h00;
    localparam logic [7:0]  CORE_CFG_RST = 8'h00;
    localparam logic [7:0]  RELOAD_LOW   = 8'h00;
    localparam logic [15:0] CNT_START    = 16'h0000;
    localparam logic [15:0] CNT_MAX      = 16'hffff;
    localparam logic [15:0] RESTART_ADDR = 16'h0000;
    localparam logic [2:0]  PULSE_TICKS  = 3'h4;

    // ----------------------------------------------------------------
    // Event bundle and pulse generator states
    // ----------------------------------------------------------------
    localparam int unsigned EVT_N = 2;

    typedef struct packed {
        logic refresh;
        logic overflow;
    } swd_evt_t;

    typedef enum logic [1:0] {
        PG_IDLE   = 2'b00,
        PG_ACTIVE = 2'b01
    } swd_pg_state_t;

endpackage : swd_pkg

// file: swd_tick_div.sv
/*
 * Divider that turns the bus clock into one-cycle slow clock ticks.
 * Assumes pclk free running; the tick is the only slow clock in the design.
 */
`timescale 1ns/10ps
module swd_tick_div #(
    parameter int unsigned DIV = swd_pkg::SLOW_DIV
) (
    input  wire logic pclk,
    input  wire logic presetn,
    output logic      tick
);
    import swd_pkg::*;

    localparam logic [15:0] DIV_M1 = 16'(DIV - 1);

    logic [15:0] div_reg;

    // ----------------------------------------------------------------
    // Free running divide counter
    // ----------------------------------------------------------------
    // Wraps every DIV cycles and flags the wrap as a tick.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg <= 16'h0000;
            tick    <= 1'b0;
        end else if (div_reg == DIV_M1) begin
            div_reg <= 16'h0000;
            tick    <= 1'b1;
        end else begin
            div_reg <= div_reg + 16'h0001;
            tick    <= 1'b0;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_tick_single : assert property (tick |=> !tick || DIV == 1)
        else $error("Slow tick lasted more than one cycle.");

endmodule : swd_tick_div

// file: swd_pulse_gen.sv
/*
 * Reset pulse generator: a start request gives a pulse four slow ticks wide.
 * Assumes tick is a one-cycle enable from the slow clock divider.
 */
`timescale 1ns/10ps
module swd_pulse_gen (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic start,
    input  wire logic tick,
    output logic      pulse
);
    import swd_pkg::*;

    swd_pg_state_t state_reg;
    logic [2:0]    ticks_reg;

    // ----------------------------------------------------------------
    // Pulse state machine
    // ----------------------------------------------------------------
    // Starts are ignored while a pulse is already running.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= PG_IDLE;
            ticks_reg <= 3'h0;
            pulse     <= 1'b0;
        end else begin
            case (state_reg)
                PG_IDLE: begin
                    if (start) begin
                        state_reg <= PG_ACTIVE;
                        ticks_reg <= 3'h0;
                        pulse     <= 1'b1;
                    end
                end
                PG_ACTIVE: begin
                    if (tick) begin
                        ticks_reg <= ticks_reg + 3'h1;
                        if (ticks_reg == PULSE_TICKS - 3'h1) begin
                            state_reg <= PG_IDLE;
                            pulse     <= 1'b0;
                        end
                    end
                end
                default: begin
                    state_reg <= PG_IDLE;
                    pulse     <= 1'b0;
                end
            endcase
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_pulse_start : assert property ($rose(pulse) |-> ticks_reg == 3'h0)
        else $error("Reset pulse began with a stale tick count.");
    a_pulse_end : assert property (
        pulse && tick && ticks_reg == 3'h3 |=> !pulse)
        else $error("Reset pulse did not end after four slow ticks.");
    a_pulse_hold : assert property (pulse && !tick |=> pulse)
        else $error("Reset pulse ended between slow ticks.");

endmodule : swd_pulse_gen

// file: swd_top.sv
/*
 * Slow clock watchdog with APB register access and a level interrupt.
 * Assumes an APB master on pclk, and that standby and debug state arrive
 * as levels synchronous to pclk.
 */
// Added by the designer: the APB register port.
// Functional notes
// - Once enabled the counter starts at zero and rises each slow tick.
// - Reaching 0xFFFF fires a system reset pulse four slow ticks wide.
// - After a watchdog reset the processor restarts at address zero.
// - Writing one to the refresh bit reloads the counter; zero does nothing.
// - The reload byte gives the upper eight bits of the reloaded count.
// - In standby or sleep the counter holds its value.
// - Under debug control the watchdog is disabled and cannot reset.
// - A watchdog reset sets the watchdog reset flag.
// - Enable bit five of the core config starts the watchdog from zero.
`timescale 1ns/10ps
module swd_top #(
    parameter int unsigned AW  = 18,
    parameter int unsigned DIV = swd_pkg::SLOW_DIV
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [AW-1:0]     paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              standby_sleep,
    input  wire logic              debug_halt,
    output logic                   wdt_reset,
    output logic      [15:0]       restart_addr,
    output logic                   irq
);
    import swd_pkg::*;

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [7:0]       reload_reg;
    logic [7:0]       core_cfg_reg;
    logic [15:0]      count_reg;
    logic [EVT_N-1:0] stat_reg;
    logic [EVT_N-1:0] ien_reg;
    logic [EVT_N-1:0] clr_bits;
    logic             rst_flag_reg;
    logic             tick;
    logic             running;
    logic             fire;
    logic             wr_fire;
    logic             setup;
    logic             refresh_wr;
    logic             irq_cond;
    logic             mapped;
    logic [31:0]      rdata_next;
    swd_evt_t         evt;

    // ----------------------------------------------------------------
    // Address decode helper
    // ----------------------------------------------------------------
    // True when the bus address is the word of the given register index.
    function automatic logic hit(input logic [AW-1:0] addr,
                                 input logic [15:0]   idx);
        hit = (addr == AW'({idx, 2'b00}));
    endfunction : hit

    // ----------------------------------------------------------------
    // Slow clock tick and reset pulse
    // ----------------------------------------------------------------
    swd_tick_div #(
        .DIV (DIV)
    ) u_tick (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (tick)
    );

    swd_pulse_gen u_pulse (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (fire),
        .tick    (tick),
        .pulse   (wdt_reset)
    );

    // ----------------------------------------------------------------
    // APB handshake
    // ----------------------------------------------------------------
    // Read data and answer are registered in the setup cycle, so every
    // transfer completes on the first access cycle.
    assign setup   = psel && !penable;
    assign wr_fire = psel && penable && pready && pwrite;

    // Every register index the slave answers for.
    always_comb begin
        mapped = 1'b0;
        if (hit(paddr, IDX_REFRESH)) begin
            mapped = 1'b1;
        end else if (hit(paddr, IDX_RELOAD)) begin
            mapped = 1'b1;
        end else if (hit(paddr, IDX_CORE_CFG)) begin
            mapped = 1'b1;
        end else if (hit(paddr, IDX_IRQ_STAT)) begin
            mapped = 1'b1;
        end else if (hit(paddr, IDX_IRQ_EN)) begin
            mapped = 1'b1;
        end else if (hit(paddr, IDX_IRQ_CLR)) begin
            mapped = 1'b1;
        end else if (hit(paddr, IDX_RST_STAT)) begin
            mapped = 1'b1;
        end
    end

    // Read multiplexer; write-only and trigger bits read as zero.
    always_comb begin
        rdata_next = 32'h0000_0000;
        if (hit(paddr, IDX_RELOAD)) begin
            rdata_next[7:0] = reload_reg;
        end else if (hit(paddr, IDX_CORE_CFG)) begin
            rdata_next[7:0] = core_cfg_reg;
        end else if (hit(paddr, IDX_IRQ_STAT)) begin
            rdata_next[EVT_N-1:0] = stat_reg;
        end else if (hit(paddr, IDX_IRQ_EN)) begin
            rdata_next[EVT_N-1:0] = ien_reg;
        end else if (hit(paddr, IDX_RST_STAT)) begin
            rdata_next[RST_FLAG_POS] = rst_flag_reg;
        end
    end

    // Answer registers: ready one cycle after setup, error on unmapped.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup;
            pslverr <= setup && !mapped;
            if (setup && !pwrite) begin
                prdata <= rdata_next;
            end
        end
    end

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    // Reload byte is accepted whether or not the watchdog runs.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reload_reg <= RELOAD_RST;
        end else if (wr_fire && hit(paddr, IDX_RELOAD)) begin
            reload_reg <= pwdata[7:0];
        end
    end

    // Core config keeps bits seven to one; bit zero is read-only zero.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_cfg_reg <= CORE_CFG_RST;
        end else if (wr_fire && hit(paddr, IDX_CORE_CFG)) begin
            core_cfg_reg <= {pwdata[7:1], 1'b0};
        end
    end

    // ----------------------------------------------------------------
    // Watchdog counter
    // ----------------------------------------------------------------
    // Debug control forces the watchdog off whatever the enable says.
    assign running    = core_cfg_reg[ENABLE_POS] && !debug_halt;
    assign refresh_wr = wr_fire && hit(paddr, IDX_REFRESH)
                        && pwdata[REFRESH_POS];
    // A single start per overflow; the pulse generator ignores repeats.
    assign fire       = running && (count_reg == CNT_MAX) && !wdt_reset;

    // Overflow beats refresh so a late refresh cannot hide the reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= CNT_START;
        end else if (!running) begin
            count_reg <= CNT_START;
        end else if (fire) begin
            count_reg <= CNT_START;
        end else if (refresh_wr) begin
            count_reg <= {reload_reg, RELOAD_LOW};
        end else if (tick && !standby_sleep) begin
            count_reg <= count_reg + 16'h0001;
        end
    end

    // The restart vector handed to the processor with each reset pulse.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            restart_addr <= RESTART_ADDR;
        end else if (fire) begin
            restart_addr <= RESTART_ADDR;
        end
    end

    // Watchdog reset flag; set wins over a same-cycle software clear.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_flag_reg <= 1'b0;
        end else if (fire) begin
            rst_flag_reg <= 1'b1;
        end else if (wr_fire && hit(paddr, IDX_RST_STAT)
                     && pwdata[RST_FLAG_POS]) begin
            rst_flag_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Interrupt status, enable and clear
    // ----------------------------------------------------------------
    assign evt.overflow = fire;
    assign evt.refresh  = refresh_wr && running;
    assign clr_bits     = (wr_fire && hit(paddr, IDX_IRQ_CLR))
                          ? pwdata[EVT_N-1:0] : '0;
    assign irq_cond     = |(stat_reg & ien_reg);

    // Interrupt enables written directly by software.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ien_reg <= '0;
        end else if (wr_fire && hit(paddr, IDX_IRQ_EN)) begin
            ien_reg <= pwdata[EVT_N-1:0];
        end
    end

    // Sticky status bits, one per event; a new event beats the clear.
    for (genvar i = 0; i < EVT_N; i++) begin : g_stat
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                stat_reg[i] <= 1'b0;
            end else if (evt[i]) begin
                stat_reg[i] <= 1'b1;
            end else if (clr_bits[i]) begin
                stat_reg[i] <= 1'b0;
            end
        end
    end

    // Level interrupt, registered.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= irq_cond;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_apb_answer_ready : assert property (setup |=> pready)
        else $error("APB setup was not answered in the next cycle.");
    a_apb_unmapped_err : assert property (setup && !mapped |=> pslverr)
        else $error("Unmapped APB access gave no error.");
    a_count_from_zero : assert property (!running |=> count_reg == CNT_START)
        else $error("Idle watchdog counter is not zero.");
    a_count_tick_step : assert property (
        running && tick && !standby_sleep && !fire && !refresh_wr
        |=> count_reg == $past(count_reg) + 16'h0001)
        else $error("Counter did not advance on a slow tick.");
    a_standby_hold : assert property (
        running && standby_sleep && !fire && !refresh_wr
        |=> $stable(count_reg))
        else $error("Counter moved during standby.");
    a_refresh_reload : assert property (
        running && refresh_wr && !fire
        |=> count_reg == {$past(reload_reg), RELOAD_LOW})
        else $error("Refresh did not load the reload byte.");
    a_overflow_pulse : assert property (fire |=> wdt_reset [*2])
        else $error("Overflow did not raise the reset pulse.");
    a_debug_no_reset : assert property (
        debug_halt && !wdt_reset |=> !wdt_reset)
        else $error("Watchdog reset fired under debug control.");
    a_reset_flag_set : assert property (fire |=> rst_flag_reg)
        else $error("Watchdog reset flag not set on overflow.");
    a_restart_zero : assert property (
        wdt_reset |-> restart_addr == RESTART_ADDR)
        else $error("Restart address is not zero during reset.");
    a_enable_bit_run : assert property (
        wr_fire && hit(paddr, IDX_CORE_CFG)
        |=> core_cfg_reg[ENABLE_POS] == $past(pwdata[ENABLE_POS]))
        else $error("Enable bit did not follow the configuration write.");
    a_irq_level : assert property (irq_cond |=> irq)
        else $error("Enabled status bit did not raise the interrupt.");

    c_overflow   : cover property (fire ##1 wdt_reset);
    c_refresh    : cover property (running && refresh_wr);
    c_standby    : cover property (running && standby_sleep && tick);
    c_irq_raised : cover property ($rose(irq));

endmodule : swd_top

// file: test_swd_top.sv
/*
 * Self-checking testbench of the slow clock watchdog top level.
 * Assumes swd_pkg and the design files are compiled first; the bench is the APB master.
 */
`timescale 1ns/10ps
module test_swd_top;
    import swd_pkg::*;

    // ----------------------------------------------------------------
    // Signals and counters
    // ----------------------------------------------------------------
    localparam int unsigned D = 4;    // Shortened slow tick divider.
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [17:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        standby_sleep;
    logic        debug_halt;
    logic        wdt_reset;
    logic [15:0] restart_addr;
    logic        irq;
    int          n_fail;
    int          total_checks;

    swd_top #(.AW(18), .DIV(D)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .standby_sleep(standby_sleep),
        .debug_halt(debug_halt), .wdt_reset(wdt_reset),
        .restart_addr(restart_addr), .irq(irq)
    );

    // The bus clock toggles every half period of 12.5 ns.
    always #12.5 pclk = ~pclk;

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    // Compares a seen value with the expected one and counts the result.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // Prints the counts and the verdict, then ends the run.
    task automatic finish_test();
        $display("checks=%0d mismatches=%0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test

    // One APB transfer; request held until pready is sampled high.
    task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            check(32'h0000_0000, 32'h0000_0001);
            finish_test();
        end
    endtask : apb

    // Writes a register and expects no error response.
    task automatic wr(input logic [15:0] idx, input logic [31:0] wd);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, idx, wd, rd, err);
        check({31'h0, err}, 32'h0000_0000);
    endtask : wr

    // Reads a register and compares data and error flag.
    task automatic rd_chk(input logic [15:0] idx, input logic [31:0] exp, input logic exp_err);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, idx, 32'h0000_0000, rd, err);
        check(rd, exp);
        check({31'h0, err}, {31'h0, exp_err});
    endtask : rd_chk

    // Waits n cycles and expects no watchdog reset meanwhile.
    task automatic wait_quiet(input int n);
        logic bad;
        bad = 1'b0;
        repeat (n) begin
            @(posedge pclk);
            if (wdt_reset !== 1'b0) bad = 1'b1;
        end
        check({31'h0, bad}, 32'h0000_0000);
    endtask : wait_quiet

    // Expects a reset pulse after t slow ticks, then checks width and restart address.
    task automatic expect_reset(input int t);
        int n;
        int w;
        n = 0;
        while (wdt_reset !== 1'b1 && n < (t + 4) * D + 20) begin
            @(posedge pclk);
            n++;
        end
        check({31'h0, (n >= (t - 2) * D && n <= (t + 1) * D + 12)}, 32'h0000_0001);
        // A pulse that never came was counted by the range check; report and stop.
        if (n >= (t + 4) * D + 20) begin
            finish_test();
        end
        check({16'h0, restart_addr}, 32'h0000_0000);
        w = 0;
        while (wdt_reset === 1'b1 && w < 8 * D) begin
            @(posedge pclk);
            w++;
        end
        check({31'h0, (w >= 3 * D + 1 && w <= 4 * D)}, 32'h0000_0001);
        // A pulse that never ended was counted by the width check; report and stop.
        if (w >= 8 * D) begin
            finish_test();
        end
    endtask : expect_reset

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [15:0] idx_list [7];
        idx_list = '{IDX_REFRESH, IDX_RELOAD, IDX_CORE_CFG, IDX_IRQ_STAT,
                     IDX_IRQ_EN, IDX_IRQ_CLR, IDX_RST_STAT};
        pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 18'h0_0000; pwdata = 32'h0000_0000;
        standby_sleep = 1'b0; debug_halt = 1'b0;
        n_fail = 0; total_checks = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;

        // Reset values of every register, and an unmapped address.
        foreach (idx_list[i]) rd_chk(idx_list[i], 32'h0000_0000, 1'b0);
        rd_chk(16'h4030, 32'h0000_0000, 1'b1);
        $display("test reset_values done");

        // Reload byte before enabling, then enable through bit five.
        wr(IDX_RELOAD, 32'h0000_00ff);
        rd_chk(IDX_RELOAD, 32'h0000_00ff, 1'b0);
        wr(IDX_CORE_CFG, 32'h0000_0021);
        rd_chk(IDX_CORE_CFG, 32'h0000_0020, 1'b0);
        $display("test enable done");

        // Refresh to the top byte and let the counter overflow.
        wr(IDX_REFRESH, 32'h0000_0001);
        expect_reset(255);
        rd_chk(IDX_RST_STAT, 32'h0000_0001, 1'b0);
        rd_chk(IDX_IRQ_STAT, 32'h0000_0003, 1'b0);
        check({31'h0, irq}, 32'h0000_0000);
        wr(IDX_IRQ_EN, 32'h0000_0001);
        repeat (2) @(posedge pclk);
        check({31'h0, irq}, 32'h0000_0001);
        wr(IDX_IRQ_CLR, 32'h0000_0003);
        rd_chk(IDX_IRQ_STAT, 32'h0000_0000, 1'b0);
        check({31'h0, irq}, 32'h0000_0000);
        wr(IDX_RST_STAT, 32'h0000_0001);
        rd_chk(IDX_RST_STAT, 32'h0000_0000, 1'b0);
        $display("test overflow done");

        // Reload written while running; low byte of the reload is zero.
        wr(IDX_RELOAD, 32'h0000_00fe);
        rd_chk(IDX_RELOAD, 32'h0000_00fe, 1'b0);
        wr(IDX_REFRESH, 32'h0000_0001);
        wait_quiet(400 * D);
        expect_reset(111);
        $display("test reload_low done");

        // Periodic refreshes keep it quiet; a zero write does not reload.
        wr(IDX_RELOAD, 32'h0000_00ff);
        repeat (3) begin
            wr(IDX_REFRESH, 32'h0000_0001);
            wait_quiet(200 * D);
        end
        wr(IDX_REFRESH, 32'h0000_0000);
        expect_reset(55);
        $display("test refresh done");

        // Standby holds the count, so the overflow comes late by that time.
        wr(IDX_REFRESH, 32'h0000_0001);
        wait_quiet(50 * D);
        standby_sleep <= 1'b1;
        wait_quiet(300 * D);
        standby_sleep <= 1'b0;
        expect_reset(205);
        $display("test standby done");

        // Debug control disables the watchdog; a refresh after release starts a fresh 255 tick count.
        wr(IDX_REFRESH, 32'h0000_0001);
        debug_halt <= 1'b1;
        wait_quiet(400 * D);
        debug_halt <= 1'b0;
        wr(IDX_REFRESH, 32'h0000_0001);
        expect_reset(255);
        $display("test debug done");
        finish_test();
    end

endmodule : test_swd_top
